// File: verilog/bbo_exec.sv
// sequencer for relative branches, i/o bit writes, shifts and transfer bit moves
// Behaviour
// [RULE1] branch on minus jumps to pc plus offset plus one when n is set
// [RULE2] branch on plus jumps when n is clear; no flags; one or two cycles
// [RULE3] signed greater-or-equal branch jumps when n xor v is zero
// [RULE4] signed less-than branch jumps when n xor v is one; no flags
// [RULE5] half carry set branch jumps when h is one; one or two cycles
// [RULE6] half carry clear branch jumps when h is zero; flags untouched
// [RULE7] transfer bit set branch jumps when t is one; one or two cycles
// [RULE8] interrupts enabled branch jumps when i is one; no flag change
// [RULE9] interrupts disabled branch jumps when i is zero; no flag change
// [RULE10] set i/o bit writes one to chosen bit only; two cycles, no flags
// [RULE11] clear i/o bit writes zero to chosen bit only; two cycles, no flags
// [RULE12] rotate left through carry; updates z, c, n, v in one cycle
// [RULE13] rotate right through carry; updates z, c, n, v in one cycle
// [RULE14] arithmetic shift right keeps bit 7; updates z, c, n, v
// [RULE15] bit store copies chosen register bit into t, one cycle
// [RULE16] bit load copies t into chosen register bit, one cycle, no flags
// [RULE17] branch offset is a signed word count, forward or backward
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module bbo_exec (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire bbo_pkg::bbo_op_t op_i,
	input wire logic [bbo_pkg::BBO_OFS_W-1:0] offset_i,
	input wire logic [bbo_pkg::BBO_PC_W-1:0] pc_i,
	input wire logic [bbo_pkg::BBO_BIT_W-1:0] bit_sel_i,
	input wire logic [bbo_pkg::BBO_DATA_W-1:0] reg_data_i,
	input wire logic [bbo_pkg::BBO_IO_AW-1:0] io_addr_i,
	input wire logic [bbo_pkg::BBO_DATA_W-1:0] io_rdata_i,
	input wire logic [bbo_pkg::BBO_DATA_W-1:0] status_register_i,
	output logic busy_o,
	output logic done_o,
	output logic pc_load_o,
	output logic [bbo_pkg::BBO_PC_W-1:0] pc_target_o,
	output logic reg_we_o,
	output logic [bbo_pkg::BBO_DATA_W-1:0] reg_wdata_o,
	output logic status_register_we_o,
	output logic [bbo_pkg::BBO_DATA_W-1:0] status_register_wdata_o,
	output logic io_rd_o,
	output logic io_we_o,
	output logic [bbo_pkg::BBO_IO_AW-1:0] io_addr_o,
	output logic [bbo_pkg::BBO_DATA_W-1:0] io_wdata_o
);
	import bbo_pkg::*;

	bbo_core_if core ();

	bbo_state_t state_reg, state_next;
	logic busy_reg, busy_next;
	logic done_reg, done_next;
	logic pc_load_reg, pc_load_next;
	logic [BBO_PC_W-1:0] pc_target_reg, pc_target_next;
	logic reg_we_reg, reg_we_next;
	logic [BBO_DATA_W-1:0] reg_wdata_reg, reg_wdata_next;
	logic status_register_we_reg, status_register_we_next;
	logic [BBO_DATA_W-1:0] status_register_wdata_reg, status_register_wdata_next;
	logic io_rd_reg, io_rd_next;
	logic io_we_reg, io_we_next;
	logic [BBO_IO_AW-1:0] io_addr_reg, io_addr_next;
	logic [BBO_DATA_W-1:0] io_wdata_reg, io_wdata_next;
	logic io_set_reg, io_set_next;
	logic [BBO_BIT_W-1:0] bit_reg, bit_next;
	logic [BBO_DATA_W-1:0] io_mask;
	logic [BBO_DATA_W-1:0] reg_mask;

	// helpers see the issuing instruction directly
	assign core.op = op_i;
	assign core.status_register = status_register_i;
	assign core.pc = pc_i;
	assign core.offset = offset_i;
	assign core.operand = reg_data_i;

	bbo_branch_unit u_branch (
		.bus(core)
	);

	bbo_shift_unit u_shift (
		.bus(core)
	);

	// one-hot masks for the addressed bit
	assign reg_mask = 8'h01 << bit_sel_i;
	assign io_mask = 8'h01 << bit_reg;

	// next values; strobes fall back to zero unless raised this cycle
	always_comb begin
		state_next = state_reg;
		busy_next = busy_reg;
		done_next = 1'b0;
		pc_load_next = 1'b0;
		pc_target_next = pc_target_reg;
		reg_we_next = 1'b0;
		reg_wdata_next = reg_wdata_reg;
		status_register_we_next = 1'b0;
		status_register_wdata_next = status_register_wdata_reg;
		io_rd_next = 1'b0;
		io_we_next = 1'b0;
		io_addr_next = io_addr_reg;
		io_wdata_next = io_wdata_reg;
		io_set_next = io_set_reg;
		bit_next = bit_reg;
		case (state_reg)
			BBO_ST_IDLE: begin
				// a start while busy is never seen, since busy leaves idle
				if (start_i) begin
					if (core.br_is) begin
						// branches never touch the status flags (see [RULE6])
						if (core.br_taken) begin
							pc_load_next = 1'b1; // see [RULE1]
							pc_target_next = core.br_target;
							busy_next = 1'b1;
							state_next = BBO_ST_BR_WAIT; // see [RULE2]
						end else begin
							done_next = 1'b1; // see [RULE2]
						end
					end else if (core.sh_is) begin
						reg_we_next = 1'b1; // see [RULE12]
						reg_wdata_next = core.sh_result; // see [RULE13]
						status_register_we_next = 1'b1; // see [RULE14]
						status_register_wdata_next = core.sh_status_register;
						done_next = 1'b1;
					end else begin
						case (op_i)
							BBO_OP_SET_IO, BBO_OP_CLR_IO: begin
								// read first so the other bits survive (see [RULE10])
								io_rd_next = 1'b1;
								io_addr_next = io_addr_i;
								io_set_next = (op_i == BBO_OP_SET_IO);
								bit_next = bit_sel_i;
								busy_next = 1'b1;
								state_next = BBO_ST_IO_WAIT; // see [RULE11]
							end
							BBO_OP_BST: begin
								status_register_wdata_next = status_register_i;
								status_register_wdata_next[BBO_FLAG_T] = |(reg_data_i & reg_mask); // see [RULE15]
								status_register_we_next = 1'b1;
								done_next = 1'b1;
							end
							BBO_OP_BLD: begin
								if (status_register_i[BBO_FLAG_T]) begin
									reg_wdata_next = reg_data_i | reg_mask; // see [RULE16]
								end else begin
									reg_wdata_next = reg_data_i & ~reg_mask;
								end
								reg_we_next = 1'b1;
								done_next = 1'b1;
							end
							default: begin
								// foreign or empty op: nothing happens, no done
								done_next = 1'b0;
							end
						endcase
					end
				end
			end
			BBO_ST_BR_WAIT: begin
				// second cycle of a taken branch while fetch refills
				done_next = 1'b1; // see [RULE7]
				busy_next = 1'b0;
				state_next = BBO_ST_IDLE;
			end
			BBO_ST_IO_WAIT: begin
				// read data stands in the cycle the read strobe is high
				if (io_set_reg) begin
					io_wdata_next = io_rdata_i | io_mask; // see [RULE10]
				end else begin
					io_wdata_next = io_rdata_i & ~io_mask; // see [RULE11]
				end
				io_we_next = 1'b1;
				done_next = 1'b1;
				busy_next = 1'b0;
				state_next = BBO_ST_IDLE;
			end
			default: begin
				busy_next = 1'b0;
				state_next = BBO_ST_IDLE;
			end
		endcase
	end

	// state registers only
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= BBO_ST_IDLE;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			pc_load_reg <= 1'b0;
			pc_target_reg <= BBO_PC_RST;
			reg_we_reg <= 1'b0;
			reg_wdata_reg <= BBO_DATA_RST;
			status_register_we_reg <= 1'b0;
			status_register_wdata_reg <= BBO_DATA_RST;
			io_rd_reg <= 1'b0;
			io_we_reg <= 1'b0;
			io_addr_reg <= BBO_IO_RST;
			io_wdata_reg <= BBO_DATA_RST;
			io_set_reg <= 1'b0;
			bit_reg <= BBO_BIT_RST;
		end else begin
			state_reg <= state_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
			pc_load_reg <= pc_load_next;
			pc_target_reg <= pc_target_next;
			reg_we_reg <= reg_we_next;
			reg_wdata_reg <= reg_wdata_next;
			status_register_we_reg <= status_register_we_next;
			status_register_wdata_reg <= status_register_wdata_next;
			io_rd_reg <= io_rd_next;
			io_we_reg <= io_we_next;
			io_addr_reg <= io_addr_next;
			io_wdata_reg <= io_wdata_next;
			io_set_reg <= io_set_next;
			bit_reg <= bit_next;
		end
	end

	// every output straight from a flip-flop
	assign busy_o = busy_reg;
	assign done_o = done_reg;
	assign pc_load_o = pc_load_reg;
	assign pc_target_o = pc_target_reg;
	assign reg_we_o = reg_we_reg;
	assign reg_wdata_o = reg_wdata_reg;
	assign status_register_we_o = status_register_we_reg;
	assign status_register_wdata_o = status_register_wdata_reg;
	assign io_rd_o = io_rd_reg;
	assign io_we_o = io_we_reg;
	assign io_addr_o = io_addr_reg;
	assign io_wdata_o = io_wdata_reg;
endmodule

// File: verilog/bbo_pkg.sv
// shared constants and types for the branch and bit operation unit
package bbo_pkg;

	// datapath widths
	localparam int BBO_PC_W = 16;
	localparam int BBO_OFS_W = 7;
	localparam int BBO_IO_AW = 6;
	localparam int BBO_DATA_W = 8;
	localparam int BBO_BIT_W = 3;

	// status register bit positions
	localparam int BBO_FLAG_C = 0;
	localparam int BBO_FLAG_Z = 1;
	localparam int BBO_FLAG_N = 2;
	localparam int BBO_FLAG_V = 3;
	localparam int BBO_FLAG_S = 4;
	localparam int BBO_FLAG_H = 5;
	localparam int BBO_FLAG_T = 6;
	localparam int BBO_FLAG_I = 7;

	// reset values
	localparam logic [BBO_DATA_W-1:0] BBO_DATA_RST = 8'h00;
	localparam logic [BBO_PC_W-1:0] BBO_PC_RST = 16'h0000;
	localparam logic [BBO_IO_AW-1:0] BBO_IO_RST = 6'h00;
	localparam logic [BBO_BIT_W-1:0] BBO_BIT_RST = 3'h0;

	// execution time in cycles
	localparam int BBO_CYC_SINGLE = 1;
	localparam int BBO_CYC_BR_TAKEN = 2;
	localparam int BBO_CYC_IO_BIT = 2;

	// branch target distance beyond the offset itself
	localparam logic [BBO_PC_W-1:0] BBO_PC_STEP = 16'h0001;

	// operations handled by this unit
	typedef enum logic [4:0] {
		BBO_OP_NONE = 5'h00,
		BBO_OP_BR_MINUS = 5'h01,
		BBO_OP_BR_PLUS = 5'h02,
		BBO_OP_BR_SGE = 5'h03,
		BBO_OP_BR_SLT = 5'h04,
		BBO_OP_BR_HSET = 5'h05,
		BBO_OP_BR_HCLR = 5'h06,
		BBO_OP_BR_TSET = 5'h07,
		BBO_OP_BR_IEN = 5'h08,
		BBO_OP_BR_IDIS = 5'h09,
		BBO_OP_SET_IO = 5'h0a,
		BBO_OP_CLR_IO = 5'h0b,
		BBO_OP_ROL = 5'h0c,
		BBO_OP_ROR = 5'h0d,
		BBO_OP_ASR = 5'h0e,
		BBO_OP_BST = 5'h0f,
		BBO_OP_BLD = 5'h10
	} bbo_op_t;

	// sequencer states, gray along idle -> branch wait only; idle -> io wait flips both bits
	typedef enum logic [1:0] {
		BBO_ST_IDLE = 2'h0,
		BBO_ST_BR_WAIT = 2'h1,
		BBO_ST_IO_WAIT = 2'h3
	} bbo_state_t;

endpackage

// File: verilog/bbo_core_if.sv
// signals between the sequencer and its branch and shift helpers
`timescale 1ns/100ps
interface bbo_core_if;
	import bbo_pkg::*;

	bbo_op_t op;
	logic [BBO_DATA_W-1:0] status_register;
	logic [BBO_PC_W-1:0] pc;
	logic [BBO_OFS_W-1:0] offset;
	logic [BBO_DATA_W-1:0] operand;
	logic br_is;
	logic br_taken;
	logic [BBO_PC_W-1:0] br_target;
	logic sh_is;
	logic [BBO_DATA_W-1:0] sh_result;
	logic [BBO_DATA_W-1:0] sh_status_register;

	modport top (output op, status_register, pc, offset, operand,
		input br_is, br_taken, br_target, sh_is, sh_result, sh_status_register);
	modport br (input op, status_register, pc, offset, output br_is, br_taken, br_target);
	modport sh (input op, status_register, operand, output sh_is, sh_result, sh_status_register);
endinterface

// File: verilog/bbo_branch_unit.sv
// branch condition evaluation and relative target adder
`timescale 1ns/100ps
module bbo_branch_unit (
	bbo_core_if.br bus
);
	import bbo_pkg::*;

	logic [BBO_PC_W-1:0] ofs_ext;

	// signed word offset, so a branch may go backward too (see [RULE17])
	assign ofs_ext = {{(BBO_PC_W-BBO_OFS_W){bus.offset[BBO_OFS_W-1]}}, bus.offset};
	// target is branch address plus offset plus one (see [RULE1])
	assign bus.br_target = bus.pc + ofs_ext + BBO_PC_STEP;

	// condition per branch kind
	always_comb begin
		bus.br_is = 1'b1;
		bus.br_taken = 1'b0;
		case (bus.op)
			BBO_OP_BR_MINUS: bus.br_taken = bus.status_register[BBO_FLAG_N]; // see [RULE1]
			BBO_OP_BR_PLUS: bus.br_taken = ~bus.status_register[BBO_FLAG_N]; // see [RULE2]
			BBO_OP_BR_SGE: begin
				bus.br_taken = ~(bus.status_register[BBO_FLAG_N] ^ bus.status_register[BBO_FLAG_V]); // see [RULE3]
			end
			BBO_OP_BR_SLT: begin
				bus.br_taken = bus.status_register[BBO_FLAG_N] ^ bus.status_register[BBO_FLAG_V]; // see [RULE4]
			end
			BBO_OP_BR_HSET: bus.br_taken = bus.status_register[BBO_FLAG_H]; // see [RULE5]
			BBO_OP_BR_HCLR: bus.br_taken = ~bus.status_register[BBO_FLAG_H]; // see [RULE6]
			BBO_OP_BR_TSET: bus.br_taken = bus.status_register[BBO_FLAG_T]; // see [RULE7]
			BBO_OP_BR_IEN: bus.br_taken = bus.status_register[BBO_FLAG_I]; // see [RULE8]
			BBO_OP_BR_IDIS: bus.br_taken = ~bus.status_register[BBO_FLAG_I]; // see [RULE9]
			default: bus.br_is = 1'b0;
		endcase
	end
endmodule

// File: verilog/bbo_shift_unit.sv
// rotate and arithmetic shift with the z, c, n, v flag update
`timescale 1ns/100ps
module bbo_shift_unit (
	bbo_core_if.sh bus
);
	import bbo_pkg::*;

	logic carry_out;
	logic [BBO_DATA_W-1:0] res;

	// result and carry per shift kind
	always_comb begin
		bus.sh_is = 1'b1;
		res = bus.operand;
		carry_out = bus.status_register[BBO_FLAG_C];
		case (bus.op)
			BBO_OP_ROL: begin
				res = {bus.operand[6:0], bus.status_register[BBO_FLAG_C]}; // see [RULE12]
				carry_out = bus.operand[7];
			end
			BBO_OP_ROR: begin
				res = {bus.status_register[BBO_FLAG_C], bus.operand[7:1]}; // see [RULE13]
				carry_out = bus.operand[0];
			end
			BBO_OP_ASR: begin
				res = {bus.operand[7], bus.operand[7:1]}; // see [RULE14]
				carry_out = bus.operand[0];
			end
			default: bus.sh_is = 1'b0;
		endcase
	end

	assign bus.sh_result = res;

	// only z, c, n, v move; overflow is n xor c of the new values
	always_comb begin
		bus.sh_status_register = bus.status_register;
		bus.sh_status_register[BBO_FLAG_Z] = (res == BBO_DATA_RST); // see [RULE12]
		bus.sh_status_register[BBO_FLAG_C] = carry_out;
		bus.sh_status_register[BBO_FLAG_N] = res[7];
		bus.sh_status_register[BBO_FLAG_V] = res[7] ^ carry_out; // see [RULE14]
	end
endmodule

// File: verification/bbo_exec_chk.sv
// port assertions for the branch and bit operation sequencer
`timescale 1ns/100ps
module bbo_exec_chk
	import bbo_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire bbo_pkg::bbo_op_t op_i,
	input wire logic [6:0] offset_i,
	input wire logic [15:0] pc_i,
	input wire logic [2:0] bit_sel_i,
	input wire logic [7:0] reg_data_i,
	input wire logic [7:0] io_rdata_i,
	input wire logic [7:0] status_register_i,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic pc_load_o,
	input wire logic [15:0] pc_target_o,
	input wire logic reg_we_o,
	input wire logic [7:0] reg_wdata_o,
	input wire logic status_register_we_o,
	input wire logic [7:0] status_register_wdata_o,
	input wire logic io_rd_o,
	input wire logic io_we_o,
	input wire logic [7:0] io_wdata_o
);
	logic tk;
	logic [15:0] pc_reg;
	logic [6:0] of_reg;
	logic [7:0] rd_reg;
	logic [7:0] sr_reg;
	logic [7:0] io_reg;
	logic [2:0] bs_reg;
	assign tk = start_i && !busy_o;
	// operands one edge back, so results can be tied to their cause
	always_ff @(posedge clk_i) begin
		pc_reg <= pc_i;
		of_reg <= offset_i;
		rd_reg <= reg_data_i;
		sr_reg <= status_register_i;
		io_reg <= io_rdata_i;
		bs_reg <= bit_sel_i;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_minus_target: assert property (
		tk && op_i == BBO_OP_BR_MINUS && status_register_i[BBO_FLAG_N] |=> pc_load_o &&
		pc_target_o == pc_reg + {{9{of_reg[6]}}, of_reg} + 16'h0001)
		else $error("minus branch target wrong");
	a_plus_skip: assert property (
		tk && op_i == BBO_OP_BR_PLUS && status_register_i[BBO_FLAG_N] |=> done_o && !pc_load_o)
		else $error("plus branch taken on n set");
	a_taken_two: assert property (
		pc_load_o |-> busy_o ##1 (done_o && !busy_o && !status_register_we_o && !reg_we_o))
		else $error("taken branch not two cycles");
	a_sge_cond: assert property (
		tk && op_i == BBO_OP_BR_SGE |=> pc_load_o == (sr_reg[BBO_FLAG_N] ~^ sr_reg[BBO_FLAG_V]))
		else $error("signed ge condition wrong");
	a_br_no_write: assert property (
		tk && op_i inside {[BBO_OP_BR_MINUS:BBO_OP_BR_IDIS]} |=> !status_register_we_o && !reg_we_o)
		else $error("branch wrote a register");
	// bit number is the one given with the start, two edges back
	a_set_io_rmw: assert property (
		tk && op_i == BBO_OP_SET_IO |=> io_rd_o && busy_o ##1
		io_we_o && done_o && io_wdata_o == (io_reg | (8'h01 << $past(bit_sel_i, 2))))
		else $error("set io bit write wrong");
	a_rol_result: assert property (
		tk && op_i == BBO_OP_ROL |=> reg_wdata_o == {rd_reg[6:0], sr_reg[BBO_FLAG_C]} &&
		status_register_wdata_o[BBO_FLAG_C] == rd_reg[7])
		else $error("rotate left result wrong");
	a_bld_copy: assert property (
		tk && op_i == BBO_OP_BLD |=> reg_we_o && !status_register_we_o &&
		reg_wdata_o[bs_reg] == sr_reg[BBO_FLAG_T])
		else $error("bit load wrong");
endmodule
bind bbo_exec bbo_exec_chk u_chk (.clk_i, .rst_n_i, .start_i, .op_i, .offset_i, .pc_i,
	.bit_sel_i, .reg_data_i, .io_rdata_i, .status_register_i, .busy_o, .done_o, .pc_load_o, .pc_target_o,
	.reg_we_o, .reg_wdata_o, .status_register_we_o, .status_register_wdata_o, .io_rd_o, .io_we_o, .io_wdata_o);

// File: verification/tb_top.sv
// self-checking bench for the branch and bit operation sequencer
`timescale 1ns/100ps
module tb_top;
	import bbo_pkg::*;
	logic clk_i;
	logic rst_n_i;
	logic start_i;
	bbo_op_t op_i;
	logic [6:0] offset_i;
	logic [15:0] pc_i, pc_target_o, st;
	logic [2:0] bit_sel_i;
	logic [7:0] reg_data_i, io_rdata_i, status_register_i, reg_wdata_o, status_register_wdata_o, io_wdata_o;
	logic [5:0] io_addr_i, io_addr_o;
	logic busy_o, done_o, pc_load_o, reg_we_o, status_register_we_o, io_rd_o, io_we_o;
	logic [7:0] sv [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h20, 8'h40, 8'h80, 8'hff};
	logic [7:0] dl [3] = '{8'h80, 8'h01, 8'hc3};
	int err_count = 0;
	int compares = 0;
	int cycles = 0;
	bbo_exec DUT (.clk_i, .rst_n_i, .start_i, .op_i, .offset_i, .pc_i, .bit_sel_i, .reg_data_i,
		.io_addr_i, .io_rdata_i, .status_register_i, .busy_o, .done_o, .pc_load_o, .pc_target_o, .reg_we_o,
		.reg_wdata_o, .status_register_we_o, .status_register_wdata_o, .io_rd_o, .io_we_o, .io_addr_o, .io_wdata_o);
	// all strobes in one word: load, done, busy, reg, status_register, io read, io write
	assign st = {9'h0, pc_load_o, done_o, busy_o, reg_we_o, status_register_we_o, io_rd_o, io_we_o};
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// hang guard, far above the few hundred cycles the tests use
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			$display("BAD %s exp %h got %h", nm, exp, got);
			err_count++;
		end
	endtask
	// one issue; returns just after the edge that takes it
	task automatic go(input bbo_op_t o, input logic [7:0] s, input logic [7:0] d);
		@(posedge clk_i);
		op_i <= o;
		status_register_i <= s;
		reg_data_i <= d;
		start_i <= 1'b1;
		@(posedge clk_i);
		start_i <= 1'b0;
		#1;
	endtask
	function automatic logic cond(input bbo_op_t o, input logic [7:0] s);
		case (o)
			BBO_OP_BR_MINUS: return s[BBO_FLAG_N];
			BBO_OP_BR_PLUS: return !s[BBO_FLAG_N];
			BBO_OP_BR_SGE: return !(s[BBO_FLAG_N] ^ s[BBO_FLAG_V]);
			BBO_OP_BR_SLT: return s[BBO_FLAG_N] ^ s[BBO_FLAG_V];
			BBO_OP_BR_HSET: return s[BBO_FLAG_H];
			BBO_OP_BR_HCLR: return !s[BBO_FLAG_H];
			BBO_OP_BR_TSET: return s[BBO_FLAG_T];
			BBO_OP_BR_IEN: return s[BBO_FLAG_I];
			default: return !s[BBO_FLAG_I];
		endcase
	endfunction
	task automatic br(input bbo_op_t o, input logic [7:0] s, input logic [6:0] k);
		logic t;
		t = cond(o, s);
		pc_i <= 16'h4000;
		offset_i <= k;
		go(o, s, 8'h00);
		chk("branch c1", t ? 16'h0050 : 16'h0020, st);
		if (t) begin
			chk("target", 16'h4001 + {{9{k[6]}}, k}, pc_target_o);
			@(posedge clk_i);
			#1;
			chk("branch c2", 16'h0020, st);
		end
	endtask
	task automatic sh(input bbo_op_t o, input logic [7:0] s, input logic [7:0] d);
		logic [7:0] r, f;
		logic c;
		case (o)
			BBO_OP_ROL: {c, r} = {d, s[0]};
			BBO_OP_ROR: {r, c} = {s[0], d};
			default: {r, c} = {d[7], d};
		endcase
		f = s;
		f[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
		go(o, s, d);
		chk("shift strobes", 16'h002c, st);
		chk("shift result", {8'h0, r}, {8'h0, reg_wdata_o});
		chk("shift flags", {8'h0, f}, {8'h0, status_register_wdata_o});
	endtask
	task automatic io(input bbo_op_t o, input logic [2:0] b, input logic [7:0] rd);
		logic [7:0] w;
		w = (o == BBO_OP_SET_IO) ? rd | (8'h01 << b) : rd & ~(8'h01 << b);
		io_addr_i <= {3'h5, b};
		bit_sel_i <= b;
		io_rdata_i <= rd;
		go(o, 8'hff, 8'h00);
		chk("io c1", 16'h0012, st);
		chk("io addr", {10'h0, 3'h5, b}, {10'h0, io_addr_o});
		// a start while busy must be dropped
		start_i <= 1'b1;
		op_i <= BBO_OP_BLD;
		@(posedge clk_i);
		start_i <= 1'b0;
		#1;
		chk("io c2", 16'h0021, st);
		chk("io data", {8'h0, w}, {8'h0, io_wdata_o});
		@(posedge clk_i);
		#1;
		chk("idle", 16'h0000, st);
	endtask
	initial begin
		rst_n_i = 1'b0;
		start_i = 1'b0;
		op_i = BBO_OP_NONE;
		offset_i = 7'h00;
		pc_i = 16'h0000;
		bit_sel_i = 3'h0;
		reg_data_i = 8'h00;
		io_addr_i = 6'h00;
		io_rdata_i = 8'h00;
		status_register_i = 8'h00;
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		#1;
		chk("reset", 16'h0000, st);
		for (int i = 1; i <= 9; i++) begin
			for (int j = 0; j < 8; j++) begin
				br(bbo_op_t'(5'(i)), sv[j], j[0] ? 7'h40 : 7'h3f);
			end
		end
		$display("branch test done");
		for (int j = 0; j < 6; j++) begin
			sh(BBO_OP_ROL, j[0] ? 8'hf1 : 8'h00, dl[j / 2]);
			sh(BBO_OP_ROR, j[0] ? 8'hf1 : 8'h00, dl[j / 2]);
			sh(BBO_OP_ASR, j[0] ? 8'hf1 : 8'h00, dl[j / 2]);
		end
		$display("shift test done");
		for (int b = 0; b < 8; b++) begin
			bit_sel_i <= 3'(b);
			go(BBO_OP_BST, 8'h40, 8'ha5);
			chk("bst strobes", 16'h0024, st);
			chk("bst flags", {8'h0, 8'h00 | (8'(8'ha5 >> b) & 8'h01) << 6},
				{8'h0, status_register_wdata_o});
			go(BBO_OP_BLD, {1'b0, b[0], 6'h0}, 8'ha5);
			chk("bld strobes", 16'h0028, st);
			chk("bld result", {8'h0, b[0] ? 8'ha5 | (8'h01 << b) : 8'ha5 & ~(8'h01 << b)},
				{8'h0, reg_wdata_o});
			io(BBO_OP_SET_IO, 3'(b), 8'h5a);
			io(BBO_OP_CLR_IO, 3'(b), 8'h5a);
		end
		$display("bit test done");
		go(BBO_OP_NONE, 8'hff, 8'hff);
		chk("unknown op", 16'h0000, st);
		$display("unknown op test done");
		print_verdict();
	end
endmodule
